// File: design/uhs_consts.svh
// Offsets, bit positions and reset values for the host select block
`ifndef UHS_CONSTS_SVH
`define UHS_CONSTS_SVH

`define UHS_MSR_ADDR      3'h6
`define UHS_MSR_DCTS_BIT  0
`define UHS_MSR_DDCD_BIT  3
`define UHS_MSR_CTS_BIT   4
`define UHS_MSR_DCD_BIT   7
`define UHS_BYTE_ZERO     8'h00
`define UHS_ADDR_ZERO     3'h0
`define UHS_DIV_ZERO      16'h0000
`define UHS_DIV_ONE       16'h0001

`endif

// File: design/uhs_pkg.sv
// Types shared by the host select block
package uhs_pkg;
    typedef logic [7:0] uhs_byte_t;      // Host data byte
    typedef logic [2:0] uhs_reg_addr_t;  // Register select value
    typedef logic [15:0] uhs_div_t;      // Baud divisor value

    // Host read access state, one-hot
    typedef enum logic [1:0] {
        UHS_ST_IDLE = 2'b01,
        UHS_ST_READ = 2'b10
    } uhs_bus_state_t;
endpackage

// File: design/uhs_baud_div.sv
// Baud clock divider producing the transmitter 16x clock
`include "uhs_consts.svh"

module uhs_baud_div (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire uhs_pkg::uhs_div_t divisor_in,
    output logic                  baud_clk_out
);
    import uhs_pkg::*;

    uhs_div_t cnt_ff;     // Position within one output period
    uhs_div_t nxt_cnt;    // Next position
    logic     baud_ff;    // Registered output level
    logic     nxt_baud;   // Next output level

    // Count 0..divisor-1; high for the first half of each period
    always_comb begin
        if (cnt_ff >= divisor_in - `UHS_DIV_ONE) begin
            nxt_cnt = `UHS_DIV_ZERO;
        end else begin
            nxt_cnt = cnt_ff + `UHS_DIV_ONE;
        end
        // Divisor 0 or 1 cannot toggle from a flop, so it holds high
        nxt_baud = (nxt_cnt < (divisor_in >> 1))
                   || (divisor_in <= `UHS_DIV_ONE);
    end

    // Period counter
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_ff <= `UHS_DIV_ZERO;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Output flop so the pin is glitch free
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            baud_ff <= 1'b0;
        end else begin
            baud_ff <= nxt_baud;
        end
    end

    assign baud_clk_out = baud_ff;

    // Helper: cycles since last rise, and divisor steadiness since then;
    // seen_ff only trusts a rise at count zero, since the first rise after
    // reset or a divisor change can come part way through a period
    uhs_div_t per_ff;
    logic     seen_ff;
    logic     steady_ff;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            per_ff    <= `UHS_DIV_ONE;
            seen_ff   <= 1'b0;
            steady_ff <= 1'b0;
        end else if (!baud_ff && nxt_baud) begin
            per_ff    <= `UHS_DIV_ONE;
            seen_ff   <= (nxt_cnt == `UHS_DIV_ZERO);
            steady_ff <= 1'b1;
        end else begin
            per_ff    <= per_ff + `UHS_DIV_ONE;
            steady_ff <= steady_ff && (divisor_in == $past(divisor_in));
        end
    end

    a_baud_period: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!baud_ff && nxt_baud && seen_ff && steady_ff && $stable(divisor_in)
         && divisor_in > `UHS_DIV_ONE)
        |-> per_ff == divisor_in)
        else $error("baud period differs from divisor");

    a_baud_high_half: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        ($rose(baud_ff) && cnt_ff == `UHS_DIV_ZERO && divisor_in == 16'h0004
         && $stable(divisor_in))
        |-> baud_ff[*2] ##1 !baud_ff)
        else $error("baud high phase wrong for divisor four");
endmodule

// File: design/uhs_top.sv
// Host select, data bus, baud output and modem status reporting block
`include "uhs_consts.svh"

module uhs_top (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  address_latch_strobe_n_in,
    input  wire uhs_pkg::uhs_reg_addr_t register_select_line_in,
    input  wire logic                  chip_select_high_a_in,
    input  wire logic                  chip_select_high_b_in,
    input  wire logic                  chip_select_low_n_in,
    input  wire logic                  read_strobe_n_in,
    input  wire logic                  read_strobe_in,
    input  wire logic                  write_strobe_n_in,
    input  wire logic                  write_strobe_in,
    input  wire uhs_pkg::uhs_byte_t     host_data_lines_in,
    input  wire uhs_pkg::uhs_byte_t     reg_read_data_in,
    input  wire uhs_pkg::uhs_div_t      divisor_in,
    input  wire logic                  modem_irq_enable_in,
    input  wire logic                  auto_cts_enable_in,
    input  wire logic                  clear_to_send_n_in,
    input  wire logic                  carrier_detect_n_in,
    output logic                       host_data_lines_oe_out,
    output uhs_pkg::uhs_byte_t          host_data_lines_out,
    output logic                       transceiver_disable_n_out,
    output logic                       tx_baud_clock_out,
    output logic                       modem_status_irq_out,
    output logic                       tx_stall_out,
    output uhs_pkg::uhs_reg_addr_t      reg_addr_out,
    output logic                       reg_read_pulse_out,
    output logic                       reg_write_pulse_out,
    output uhs_pkg::uhs_byte_t          reg_write_data_out
);
    import uhs_pkg::*;

    // Either polarity of a strobe counts; the unused one sits inactive
    function automatic logic strobe_active(input logic low_n,
                                           input logic high);
        strobe_active = !low_n || high;
    endfunction

    uhs_reg_addr_t  hold_addr_ff;   // Register select held by the strobe
    logic           hold_csa_ff;    // Held high-active select A
    logic           hold_csb_ff;    // Held high-active select B
    logic           hold_csn_ff;    // Held low-active select
    uhs_reg_addr_t  eff_addr;       // Register select seen by decoding
    logic           eff_sel;        // Chip selected after decoding
    logic           rd_req;         // Selected read in progress
    logic           wr_req;         // Selected write in progress
    logic           wr_req_d_ff;    // Write request one cycle ago
    uhs_bus_state_t state_ff;       // Read access state
    uhs_bus_state_t nxt_state;      // Next read access state
    logic           rd_start;       // First cycle of a read
    logic           msr_read;       // First cycle of a status read
    logic           primed_ff;      // Pin history valid after reset
    logic           cts_prev_ff;    // Previous CTS pin sample
    logic           dcd_prev_ff;    // Previous DCD pin sample
    logic           cts_delta_ff;   // CTS changed since last status read
    logic           dcd_delta_ff;   // DCD changed since last status read
    logic           cts_chg;        // CTS pin moved this cycle
    logic           dcd_chg;        // DCD pin moved this cycle
    uhs_byte_t      msr_byte;       // Modem status value as read
    uhs_byte_t      data_ff;        // Registered read data
    logic           oe_ff;          // Registered bus drive enable
    logic           transceiver_disable_n_n_ff;      // Registered transceiver disable
    logic           irq_ff;         // Registered modem status interrupt
    logic           stall_ff;       // Registered transmit stall
    uhs_reg_addr_t  addr_ff;        // Registered decoded address
    logic           rd_pulse_ff;    // Registered read pulse
    logic           wr_pulse_ff;    // Registered write pulse
    uhs_byte_t      wr_data_ff;     // Registered write data

    // Follow the select pins while the strobe is low; the last low-phase
    // value stays put once the strobe goes high
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hold_addr_ff <= `UHS_ADDR_ZERO;
            hold_csa_ff  <= 1'b0;
            hold_csb_ff  <= 1'b0;
            hold_csn_ff  <= 1'b1;
        end else if (!address_latch_strobe_n_in) begin
            hold_addr_ff <= register_select_line_in;
            hold_csa_ff  <= chip_select_high_a_in;
            hold_csb_ff  <= chip_select_high_b_in;
            hold_csn_ff  <= chip_select_low_n_in;
        end
    end

    // Select decoding: live pins during strobe low, held values otherwise
    always_comb begin
        if (!address_latch_strobe_n_in) begin
            eff_addr = register_select_line_in;
            eff_sel  = chip_select_high_a_in && chip_select_high_b_in
                       && !chip_select_low_n_in;
        end else begin
            eff_addr = hold_addr_ff;
            eff_sel  = hold_csa_ff && hold_csb_ff && !hold_csn_ff;
        end
        rd_req = eff_sel && strobe_active(read_strobe_n_in,
                                          read_strobe_in);
        wr_req = eff_sel && strobe_active(write_strobe_n_in,
                                          write_strobe_in);
    end

    // Read state: leave idle on a selected read, return when it ends
    always_comb begin
        unique case (state_ff)
            UHS_ST_IDLE: nxt_state = rd_req ? UHS_ST_READ : UHS_ST_IDLE;
            UHS_ST_READ: nxt_state = rd_req ? UHS_ST_READ : UHS_ST_IDLE;
            default:     nxt_state = UHS_ST_IDLE;
        endcase
        rd_start = (state_ff == UHS_ST_IDLE) && rd_req;
        msr_read = rd_start && (eff_addr == `UHS_MSR_ADDR);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= UHS_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Modem pin history; the first sample after reset is not a change
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            primed_ff   <= 1'b0;
            cts_prev_ff <= 1'b1;
            dcd_prev_ff <= 1'b1;
        end else begin
            primed_ff   <= 1'b1;
            cts_prev_ff <= clear_to_send_n_in;
            dcd_prev_ff <= carrier_detect_n_in;
        end
    end

    assign cts_chg = primed_ff && (clear_to_send_n_in != cts_prev_ff);
    assign dcd_chg = primed_ff && (carrier_detect_n_in != dcd_prev_ff);

    // Change flags; a change in the clearing cycle wins over the clear
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cts_delta_ff <= 1'b0;
            dcd_delta_ff <= 1'b0;
        end else begin
            cts_delta_ff <= cts_chg || (cts_delta_ff && !msr_read);
            dcd_delta_ff <= dcd_chg || (dcd_delta_ff && !msr_read);
        end
    end

    // Status byte: pins are active low, so levels read inverted
    always_comb begin
        msr_byte                    = `UHS_BYTE_ZERO;
        msr_byte[`UHS_MSR_CTS_BIT]  = !clear_to_send_n_in;
        msr_byte[`UHS_MSR_DCD_BIT]  = !carrier_detect_n_in;
        msr_byte[`UHS_MSR_DCTS_BIT] = cts_delta_ff;
        msr_byte[`UHS_MSR_DDCD_BIT] = dcd_delta_ff;
    end

    // Read data is frozen at the start of the access so the cleared
    // flags never show up half way through a read
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_ff <= `UHS_BYTE_ZERO;
        end else if (rd_start) begin
            data_ff <= msr_read ? msr_byte : reg_read_data_in;
        end
    end

    // Bus drive and transceiver control follow the read state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            oe_ff     <= 1'b0;
            transceiver_disable_n_n_ff <= 1'b1;
        end else begin
            oe_ff     <= rd_req;
            transceiver_disable_n_n_ff <= !rd_req;
        end
    end

    // Interrupt is a level while a qualifying change flag is pending
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= modem_irq_enable_in
                      && ((cts_delta_ff && !auto_cts_enable_in)
                          || dcd_delta_ff);
        end
    end

    // CTS only holds the transmitter off in auto mode
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stall_ff <= 1'b0;
        end else begin
            stall_ff <= auto_cts_enable_in && clear_to_send_n_in;
        end
    end

    // Decoded address and access pulses for the register file beyond
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_ff     <= `UHS_ADDR_ZERO;
            rd_pulse_ff <= 1'b0;
            wr_req_d_ff <= 1'b0;
            wr_pulse_ff <= 1'b0;
            wr_data_ff  <= `UHS_BYTE_ZERO;
        end else begin
            addr_ff     <= eff_addr;
            rd_pulse_ff <= rd_start;
            wr_req_d_ff <= wr_req;
            wr_pulse_ff <= wr_req && !wr_req_d_ff;
            if (wr_req && !wr_req_d_ff) begin
                wr_data_ff <= host_data_lines_in;
            end
        end
    end

    uhs_baud_div u_baud_div (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .divisor_in   (divisor_in),
        .baud_clk_out (tx_baud_clock_out)
    );

    assign host_data_lines_oe_out    = oe_ff;
    assign host_data_lines_out       = data_ff;
    assign transceiver_disable_n_out = transceiver_disable_n_n_ff;
    assign modem_status_irq_out      = irq_ff;
    assign tx_stall_out              = stall_ff;
    assign reg_addr_out              = addr_ff;
    assign reg_read_pulse_out        = rd_pulse_ff;
    assign reg_write_pulse_out       = wr_pulse_ff;
    assign reg_write_data_out        = wr_data_ff;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_msr_read_start;
        msr_read && !cts_chg && !dcd_chg;
    endsequence

    a_strobe_pass: assert property (!address_latch_strobe_n_in
        |=> reg_addr_out == $past(register_select_line_in))
        else $error("select lines not passed while strobe low");
    a_strobe_hold: assert property ((address_latch_strobe_n_in
        && $past(address_latch_strobe_n_in)) |-> $stable(hold_addr_ff))
        else $error("held select changed while strobe high");
    a_chip_unsel: assert property ((state_ff == UHS_ST_IDLE
        && !(chip_select_high_a_in && chip_select_high_b_in
        && !chip_select_low_n_in) && !address_latch_strobe_n_in)
        |=> !reg_read_pulse_out && !host_data_lines_oe_out)
        else $error("access taken while unselected");
    a_cts_change: assert property (cts_chg |=> cts_delta_ff)
        else $error("CTS change not flagged");
    a_dcd_change: assert property (dcd_chg |=> dcd_delta_ff)
        else $error("DCD change not flagged");
    a_msr_clear: assert property (s_msr_read_start
        |=> !cts_delta_ff && !dcd_delta_ff ##1 host_data_lines_oe_out
        || !$past(rd_req))
        else $error("status read did not clear change flags");
    a_msr_data: assert property (msr_read |=> host_data_lines_out
        [`UHS_MSR_CTS_BIT] == !$past(clear_to_send_n_in)
        && host_data_lines_oe_out)
        else $error("status read data wrong");
    a_cts_irq_auto: assert property ((auto_cts_enable_in && !dcd_delta_ff)
        |=> !modem_status_irq_out)
        else $error("CTS interrupt raised in auto mode");
    a_dcd_irq: assert property ((modem_irq_enable_in && dcd_delta_ff)
        |=> modem_status_irq_out)
        else $error("DCD change raised no interrupt");
    a_stall_manual: assert property (!auto_cts_enable_in
        |=> !tx_stall_out)
        else $error("CTS stalled transmit outside auto mode");
    a_transceiver_disable_n_read: assert property (transceiver_disable_n_out
        == !host_data_lines_oe_out)
        else $error("transceiver disable not tied to reads");
    a_oe_read_only: assert property (host_data_lines_oe_out
        |-> $past(rd_req))
        else $error("bus driven outside a selected read");
endmodule

// File: testbench/uhs_host_model.sv
// Host CPU model driving the parallel side of the host select block
module uhs_host_model (
    input  wire logic                   clk_in,
    input  wire logic                   bus_oe_in,
    input  wire uhs_pkg::uhs_byte_t     bus_in,
    output logic                        as_n_out,
    output uhs_pkg::uhs_reg_addr_t      addr_out,
    output logic [2:0]                  cs_out,
    output logic                        rd_n_out,
    output logic                        rd_out,
    output logic                        wr_n_out,
    output logic                        wr_out,
    output uhs_pkg::uhs_byte_t          drv_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import uhs_pkg::*;

    // Idle: transparent strobe, unselected, read and write strobes inactive
    initial begin
        as_n_out = 1'b0;
        addr_out = 3'h0;
        cs_out   = 3'b001;
        rd_n_out = 1'b1;
        rd_out   = 1'b0;
        wr_n_out = 1'b1;
        wr_out   = 1'b0;
        drv_out  = 8'hA5;
    end

    // One access; cs is {high_a, high_b, low_n}; hi picks the strobe pair
    task automatic access(input logic wr_op, input logic hi,
                          input uhs_reg_addr_t a, input logic [2:0] cs,
                          input uhs_byte_t d, output uhs_byte_t q,
                          output logic got);
        got = 1'b0;
        q   = 8'h00;
        @(posedge clk_in);
        #1;
        addr_out = a;
        cs_out   = cs;
        rd_n_out = wr_op || hi;
        rd_out   = !wr_op && hi;
        wr_n_out = !wr_op || hi;
        wr_out   = wr_op && hi;
        drv_out  = wr_op ? d : ~drv_out;
        // Hold everything until the answer is seen, bounded for refusals
        for (int i = 0; i < 3 && !got; i++) begin
            @(posedge clk_in);
            #1;
            got = (bus_oe_in === 1'b1);
            q   = bus_in;
        end
        rd_n_out = 1'b1;
        rd_out   = 1'b0;
        wr_n_out = 1'b1;
        wr_out   = 1'b0;
        cs_out   = 3'b001;
        // Released bus shows no stale value
        drv_out  = ~drv_out;
    endtask

    // Strobe low with given pins, then rise; live pins then wander off
    task automatic latch(input uhs_reg_addr_t a, input logic [2:0] cs);
        @(posedge clk_in);
        #1;
        as_n_out = 1'b0;
        addr_out = a;
        cs_out   = cs;
        @(posedge clk_in);
        #1;
        as_n_out = 1'b1;
        addr_out = ~a;
        cs_out   = ~cs;
    endtask
endmodule

// File: testbench/test_uhs_top.sv
// Self-checking bench for the host select block
`include "uhs_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module test_uhs_top;
    timeunit 1ns;
    timeprecision 100ps;
    import uhs_pkg::*;

    logic          clk_in, rst_n_in, as_n, rd_n, rd, wr_n, wr, g;
    logic          irq_en, auto, cts_n, dcd_n, oe, transceiver_disable_n_n, baud, irq;
    logic          stall, rpulse, wpulse;
    logic [2:0]    cs;
    logic [4:0]    m;
    logic [31:0]   seed = 32'h6B69DD55;    // Fixed so runs repeat
    uhs_reg_addr_t addr, raddr;
    uhs_byte_t     drv, bus, rrd, dout, wdata, q;
    uhs_div_t      div;
    int            n_mismatch = 0;
    int            checks = 0;
    int            n_wp = 0;               // Write pulses seen

    // Wire level: the block wins while it drives, else the host value
    assign bus = oe ? dout : drv;

    uhs_top i_uhs_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .address_latch_strobe_n_in(as_n), .register_select_line_in(addr),
        .chip_select_high_a_in(cs[2]), .chip_select_high_b_in(cs[1]),
        .chip_select_low_n_in(cs[0]), .read_strobe_n_in(rd_n),
        .read_strobe_in(rd), .write_strobe_n_in(wr_n),
        .write_strobe_in(wr), .host_data_lines_in(bus),
        .reg_read_data_in(rrd), .divisor_in(div),
        .modem_irq_enable_in(irq_en), .auto_cts_enable_in(auto),
        .clear_to_send_n_in(cts_n), .carrier_detect_n_in(dcd_n),
        .host_data_lines_oe_out(oe), .host_data_lines_out(dout),
        .transceiver_disable_n_out(transceiver_disable_n_n), .tx_baud_clock_out(baud),
        .modem_status_irq_out(irq), .tx_stall_out(stall),
        .reg_addr_out(raddr), .reg_read_pulse_out(rpulse),
        .reg_write_pulse_out(wpulse), .reg_write_data_out(wdata));

    uhs_host_model i_uhs_host_model (.clk_in(clk_in), .bus_oe_in(oe),
        .bus_in(bus), .as_n_out(as_n), .addr_out(addr), .cs_out(cs),
        .rd_n_out(rd_n), .rd_out(rd), .wr_n_out(wr_n), .wr_out(wr),
        .drv_out(drv));

    // Clock at 200 MHz
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // Xorshift source for repeatable random stimulus
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Status byte expected from pin levels and change flags
    function automatic uhs_byte_t modem_status_register(logic c_n, logic d_n, logic fc,
                                      logic fd);
        modem_status_register = 8'h00;
        modem_status_register[`UHS_MSR_CTS_BIT]  = !c_n;
        modem_status_register[`UHS_MSR_DCD_BIT]  = !d_n;
        modem_status_register[`UHS_MSR_DCTS_BIT] = fc;
        modem_status_register[`UHS_MSR_DDCD_BIT] = fd;
    endfunction

    task automatic step();
        @(posedge clk_in);
        #1;
    endtask

    task automatic rd_msr(input logic hi);
        i_uhs_host_model.access(1'b0, hi, `UHS_MSR_ADDR, 3'b110, 8'h00,
                                q, g);
    endtask

    // Period and high time of the baud pin for one divisor
    task automatic baud_chk(input int d);
        int hi_n;
        int lo_n;
        hi_n = 0;
        lo_n = 0;
        // Change the divisor only in a low phase, never mid high phase
        for (int i = 0; i < 40 && baud !== 1'b0; i++) step();
        div = d[15:0];
        repeat (2 * d + 2) step();
        for (int i = 0; i < 40 && baud !== 1'b0; i++) step();
        for (int i = 0; i < 40 && baud !== 1'b1; i++) step();
        for (int i = 0; i < 40 && baud === 1'b1; i++) begin
            hi_n++;
            step();
        end
        for (int i = 0; i < 40 && baud === 1'b0; i++) begin
            lo_n++;
            step();
        end
        `CHK("baud_high", d / 2, hi_n)
        `CHK("baud_period", d, hi_n + lo_n)
    endtask

    // Count write pulses away from the edge that launches them
    always @(negedge clk_in) begin
        if (wpulse === 1'b1) n_wp++;
    end

    // Driver disable mirrors the bus enable on every cycle
    always @(negedge clk_in) begin
        if (rst_n_in) begin
            `CHK("transceiver_disable_n", ~oe, transceiver_disable_n_n)
        end
    end

    task automatic end_of_test();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #200us;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        rst_n_in = 1'b0;
        rrd = 8'h3C;
        div = 16'h0004;
        irq_en = 1'b0;
        auto = 1'b0;
        cts_n = 1'b1;
        dcd_n = 1'b1;
        repeat (6) step();
        rst_n_in = 1'b1;
        `CHK("oe_rst", 1'b0, oe)
        rd_msr(1'b0);
        `CHK("msr_idle", modem_status_register(cts_n, dcd_n, 1'b0, 1'b0), q)
        // Pin changes, interrupt gating and clear on read
        for (int k = 0; k < 14; k++) begin
            m = (k == 0) ? 5'b10111 : 5'(rnd());
            cts_n ^= m[0];
            dcd_n ^= m[1];
            auto = m[2];
            irq_en = m[4];
            // Flag sets at the first edge, interrupt one edge later
            step();
            `CHK("irq_early", 1'b0, irq)
            step();
            step();
            `CHK("irq", irq_en & ((m[0] & !auto) | m[1]), irq)
            `CHK("stall", auto & cts_n, stall)
            rd_msr(m[3]);
            `CHK("msr", modem_status_register(cts_n, dcd_n, m[0], m[1]), q)
            rd_msr(!m[3]);
            `CHK("msr_clr", modem_status_register(cts_n, dcd_n, 1'b0, 1'b0), q)
        end
        // Every select combination with both read strobes
        for (int s = 0; s < 16; s++) begin
            rrd = 8'(rnd());
            m = 5'(rnd());
            if (m[2:0] == `UHS_MSR_ADDR) m[2:0] = 3'h0;
            i_uhs_host_model.access(1'b0, s[3], m[2:0], s[2:0], 8'h00, q, g);
            `CHK("selected", s[2:0] == 3'b110, g)
            `CHK("rd_pulse", g, rpulse)
            if (g) `CHK("rd_data", rrd, q)
            rrd = 8'(rnd());
            n_wp = 0;
            i_uhs_host_model.access(1'b1, s[3], 3'h1, s[2:0], rrd, q, g);
            `CHK("wr_pulse", int'(s[2:0] == 3'b110), n_wp)
            if (s[2:0] == 3'b110) wdata_exp(rrd);
        end
        // Captured selects outlive the live pins while strobe is high
        i_uhs_host_model.latch(`UHS_MSR_ADDR, 3'b110);
        i_uhs_host_model.access(1'b0, 1'b0, 3'h0, 3'b000, 8'h00, q, g);
        `CHK("latched_rd", 1'b1, g)
        `CHK("latched_addr", `UHS_MSR_ADDR, raddr)
        `CHK("latched_msr", modem_status_register(cts_n, dcd_n, 1'b0, 1'b0), q)
        i_uhs_host_model.latch(`UHS_MSR_ADDR, 3'b011);
        i_uhs_host_model.access(1'b0, 1'b1, 3'h6, 3'b110, 8'h00, q, g);
        `CHK("latched_off", 1'b0, g)
        i_uhs_host_model.latch(3'h2, 3'b110);
        step();
        i_uhs_host_model.as_n_out = 1'b0;
        rd_msr(1'b1);
        `CHK("transparent", 1'b1, g)
        `CHK("transparent_addr", `UHS_MSR_ADDR, raddr)
        // Baud divisor corners, then random ones
        baud_chk(2);
        baud_chk(3);
        for (int k = 0; k < 3; k++) baud_chk(2 + rnd() % 9);
        end_of_test();
    end

    // Write data captured from the wire
    task automatic wdata_exp(input uhs_byte_t d);
        `CHK("wr_data", d, wdata)
    endtask
endmodule
